// ==== src/scc_pkg.sv ====
// Package for the serial channel configuration selector.
// Assumes one 250 MHz system clock and a synchronous active-low reset.
package scc_pkg;

  // System clock
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned CLK_HZ          = CLK_MHZ * 1000000;

  // Button hold time in milliseconds and the derived cycle count
  localparam int unsigned HOLD_MS         = 2000;
  localparam int unsigned HOLD_CYCLES     = HOLD_MS * (CLK_HZ / 1000);
  // Fewest hold cycles the counter can serve: entry cycle plus toggle cycle
  localparam int unsigned HOLD_MIN        = 2;

  // Bit rate selection codes, lowest rate first
  typedef enum logic [2:0] {
    SCC_BAUD_300   = 3'h0,
    SCC_BAUD_600   = 3'h1,
    SCC_BAUD_1200  = 3'h2,
    SCC_BAUD_2400  = 3'h3,
    SCC_BAUD_4800  = 3'h4,
    SCC_BAUD_9600  = 3'h5,
    SCC_BAUD_19200 = 3'h6,
    SCC_BAUD_38400 = 3'h7
  } scc_baud_e;

  // Control-line handshaking modes
  typedef enum logic [0:0] {
    SCC_HS_NONE  = 1'h0,
    SCC_HS_MODEM = 1'h1
  } scc_hs_e;

  // Timeout tick in milliseconds
  localparam int unsigned ACK_TICK_MS     = 20;
  localparam logic [15:0] ACK_TO_MIN      = 16'h0001;
  localparam logic [15:0] ACK_TO_DEFAULT  = 16'h0032;
  localparam logic [1:0]  STOP_BITS       = 2'h1;

  // One channel parameter set
  typedef struct packed {
    scc_baud_e   baud;
    scc_hs_e     handshake;
    logic [15:0] ack_timeout;
  } scc_cfg_s;

  localparam scc_cfg_s CFG_DEFAULT = '{
    baud:        SCC_BAUD_19200,
    handshake:   SCC_HS_NONE,
    ack_timeout: ACK_TO_DEFAULT
  };

  // Hold detector states
  typedef enum logic [1:0] {
    SCC_ST_IDLE = 2'h0,
    SCC_ST_HOLD = 2'h1,
    SCC_ST_WAIT = 2'h2
  } scc_state_e;

  // Whole state of the selector
  typedef struct packed {
    logic [2:0]  btn_sync;
    scc_state_e  state;
    logic [31:0] hold_cnt;
    logic        use_default;
    logic        first_done;
    scc_cfg_s    user_cfg;
    scc_cfg_s    ch0_cfg;
    logic        toggle_pulse;
    logic        indicator;
  } scc_state_s;

endpackage

// ==== src/scc_config_select.sv ====
// Configuration holder and selector for serial channel 0.
// Assumes the button pin is asynchronous and active high while pressed,
// and that other channels take their settings from elsewhere.
module scc_config_select
  import scc_pkg::*;
#(
  parameter int unsigned HOLD_COUNT = HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Button and firmware events
  input  wire logic        toggle_btn,
  input  wire logic        first_powerup,
  input  wire logic        fw_upgrade_done,
  // User-defined parameter set
  input  wire logic        user_wr,
  input  wire scc_cfg_s    user_cfg_in,
  // Active channel 0 parameters
  output scc_cfg_s         ch0_cfg,
  output logic [1:0]       ch0_stop_bits,
  output logic             default_comm_indicator,
  output logic             toggle_event
);

  // Elaboration check; shorter holds would underflow the compare value
  if (HOLD_COUNT < HOLD_MIN) begin
    $error("HOLD_COUNT must be at least 2");
  end

  scc_state_s s_reg;
  scc_state_s s_next;

  // Timeout value checked for legal range before storing
  function automatic logic cfg_ok(input scc_cfg_s c);
    cfg_ok = (c.ack_timeout >= ACK_TO_MIN);
  endfunction

  // Next state: sync, hold timing, set selection
  always_comb begin
    s_next = s_reg;
    s_next.toggle_pulse = 1'b0;
    s_next.btn_sync = {s_reg.btn_sync[1:0], toggle_btn};
    case (s_reg.state)
      SCC_ST_IDLE: begin
        s_next.hold_cnt = '0;
        if (s_reg.btn_sync[2]) begin
          s_next.state = SCC_ST_HOLD;
        end
      end
      SCC_ST_HOLD: begin
        if (!s_reg.btn_sync[2]) begin
          s_next.state = SCC_ST_IDLE; // Any release restarts timing
        end else if (s_reg.hold_cnt == 32'(HOLD_COUNT - HOLD_MIN)) begin
          s_next.state = SCC_ST_WAIT;
          s_next.toggle_pulse = 1'b1;
          s_next.use_default = ~s_reg.use_default;
        end else begin
          s_next.hold_cnt = s_reg.hold_cnt + 32'h1;
        end
      end
      SCC_ST_WAIT: begin
        // Held button never toggles twice
        if (!s_reg.btn_sync[2]) begin
          s_next.state = SCC_ST_IDLE;
        end
      end
      default: s_next.state = SCC_ST_IDLE;
    endcase
    // User writes stored even while defaults are active; bad ones dropped
    if (user_wr && cfg_ok(user_cfg_in)) begin
      s_next.user_cfg = user_cfg_in;
    end
    // Firmware events win over the button in the same cycle
    if ((first_powerup && !s_reg.first_done) || fw_upgrade_done) begin
      s_next.use_default = 1'b1;
      s_next.first_done = s_reg.first_done | first_powerup;
    end
    // Only channel 0 sees the selected set
    s_next.ch0_cfg = s_next.use_default ? CFG_DEFAULT : s_next.user_cfg;
    s_next.indicator = s_next.use_default;
  end

  // State register; reset comes up in defaults
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_reg <= '{btn_sync: 3'h0, state: SCC_ST_IDLE, hold_cnt: 32'h0,
                 use_default: 1'b1, first_done: 1'b0,
                 user_cfg: CFG_DEFAULT, ch0_cfg: CFG_DEFAULT,
                 toggle_pulse: 1'b0, indicator: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register, except the constant stop bits
  assign ch0_cfg                = s_reg.ch0_cfg;
  assign ch0_stop_bits          = STOP_BITS; // Fixed framing
  assign default_comm_indicator = s_reg.indicator;
  assign toggle_event           = s_reg.toggle_pulse;

  // Assertion clock and reset for everything below
  default clocking cb_sys @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // Cycles the synchronised button has been seen high, saturating
  int unsigned hold_len;
  always_ff @(posedge sys_clk) begin
    if (!rstn || !s_reg.btn_sync[2]) begin
      hold_len <= 0;
    end else if (hold_len < HOLD_COUNT + 8) begin
      hold_len <= hold_len + 1;
    end
  end

  // Set by a toggle, cleared once the button is seen released; a
  // second toggle while it is set means one hold toggled twice
  logic rel_pending;
  always_ff @(posedge sys_clk) begin
    if (!rstn || !s_reg.btn_sync[2]) begin
      rel_pending <= 1'b0;
    end else if (toggle_event) begin
      rel_pending <= 1'b1;
    end
  end

  // A hold that has just run its full length
  sequence s_hold_full;
    hold_len == HOLD_COUNT;
  endsequence

  // User writes that must be stored
  sequence s_good_write;
    user_wr && user_cfg_in.ack_timeout >= ACK_TO_MIN;
  endsequence

  // User writes that must be refused
  sequence s_bad_write;
    user_wr && user_cfg_in.ack_timeout < ACK_TO_MIN;
  endsequence

  // Indicator moves only on a toggle or a forced load of defaults
  a_indicator_match: assert property (
    $changed(default_comm_indicator) |->
      toggle_event || $past(fw_upgrade_done) || $past(first_powerup))
    else $error("indicator changed without a cause");

  // Default set must be the one presented while the indicator is on
  a_default_values: assert property (
    default_comm_indicator |-> ch0_cfg == CFG_DEFAULT)
    else $error("default set not applied");

  // Only the stored user set reaches channel 0 otherwise
  a_user_values: assert property (
    !default_comm_indicator |-> ch0_cfg == s_reg.user_cfg)
    else $error("user set not applied");

  // A zero timeout would stall the link, so it must never be active
  a_timeout_range: assert property (
    ch0_cfg.ack_timeout >= ACK_TO_MIN)
    else $error("ack timeout below one count");

  // Framing never changes, whatever set is selected
  a_stop_fixed: assert property (
    ch0_stop_bits == 2'h1)
    else $error("stop bits not one");

  // No toggle before the full hold has been seen
  a_hold_time: assert property (
    toggle_event |-> $past(hold_len) >= HOLD_COUNT - 1)
    else $error("toggle before full hold");

  // A full hold toggles in the very cycle it completes
  a_hold_fires: assert property (
    s_hold_full |-> toggle_event)
    else $error("full hold gave no toggle");

  // Toggle swaps the sets unless a forced load wins the same cycle
  a_toggle_flip: assert property (
    (toggle_event && !$past(fw_upgrade_done) && !$past(first_powerup))
    |-> default_comm_indicator != $past(default_comm_indicator))
    else $error("toggle did not swap sets");

  // A held button must be released before it can toggle again
  a_one_per_hold: assert property (
    toggle_event |-> !rel_pending)
    else $error("second toggle in one hold");

  // Toggle event is a single-cycle pulse
  a_pulse_width: assert property (
    toggle_event |=> !toggle_event)
    else $error("toggle event longer than one cycle");

  // Firmware upgrade forces defaults on the next cycle
  a_upgrade_default: assert property (
    fw_upgrade_done |=> default_comm_indicator)
    else $error("upgrade did not load defaults");

  // First power-up after reset forces defaults once
  a_powerup_default: assert property (
    first_powerup && !s_reg.first_done |=> default_comm_indicator)
    else $error("power-up did not load defaults");

  // Default handshaking is none
  a_hs_default: assert property (
    default_comm_indicator |-> ch0_cfg.handshake == SCC_HS_NONE)
    else $error("default handshake not none");

  // Legal writes land in the user set one cycle later
  a_user_stored: assert property (
    s_good_write |=> s_reg.user_cfg == $past(user_cfg_in))
    else $error("user write not stored");

  // Writes with a zero timeout leave the user set untouched
  a_user_refused: assert property (
    s_bad_write |=> $stable(s_reg.user_cfg))
    else $error("zero timeout write stored");

endmodule

// ==== test/scc_btn_model.sv ====
// Operator model that presses the channel 0 toggle button.
// Assumes the bench clock; a released button is pulled low.
module scc_btn_model (
  // Clock
  input  wire logic sys_clk,
  // Button pin
  output logic      toggle_btn
);
  timeunit 1ns;
  timeprecision 1ps;

  initial toggle_btn = 1'b0;

  // Hold n cycles, then release; falling edge keeps clear of sampling
  task automatic press(input int n);
    @(negedge sys_clk);
    toggle_btn = 1'b1;
    repeat (n) @(negedge sys_clk);
    toggle_btn = 1'b0;
  endtask
endmodule

// ==== test/test_serial_channel_config_select.sv ====
// Bench for the channel 0 configuration selector.
// Assumes a 250 MHz clock and a hold count cut down to 20.
module test_serial_channel_config_select;
  timeunit 1ns;
  timeprecision 1ps;
  import scc_pkg::*;

  logic       sys_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       toggle_btn;
  logic       first_powerup = 1'b0;
  logic       fw_upgrade_done = 1'b0;
  logic       user_wr = 1'b0;
  scc_cfg_s   user_cfg_in = CFG_DEFAULT;
  scc_cfg_s   ch0_cfg;
  logic [1:0] ch0_stop_bits;
  logic       default_comm_indicator;
  logic       toggle_event;
  int         errors = 0;
  int         check_count = 0;
  int         n_tog = 0;
  int         cycles = 0;
  localparam scc_cfg_s UCFG = '{SCC_BAUD_38400, SCC_HS_MODEM, ACK_TO_MIN};
  localparam scc_cfg_s BAD = '{SCC_BAUD_300, SCC_HS_NONE, 16'h0000};

  scc_config_select #(.HOLD_COUNT(20)) scc_config_select_inst (
    .sys_clk(sys_clk), .rstn(rstn), .toggle_btn(toggle_btn),
    .first_powerup(first_powerup), .fw_upgrade_done(fw_upgrade_done),
    .user_wr(user_wr), .user_cfg_in(user_cfg_in), .ch0_cfg(ch0_cfg),
    .ch0_stop_bits(ch0_stop_bits),
    .default_comm_indicator(default_comm_indicator),
    .toggle_event(toggle_event));
  scc_btn_model scc_btn_model_inst (.sys_clk(sys_clk),
    .toggle_btn(toggle_btn));

  always #2 sys_clk = ~sys_clk;

  task automatic give_verdict;
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk_cfg(input scc_cfg_s got, input scc_cfg_s exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pulse counter and hang guard; 5000 cycles is far past the run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (toggle_event === 1'b1) n_tog <= n_tog + 1;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic wr(input scc_cfg_s c);
    @(negedge sys_clk);
    user_cfg_in = c;
    user_wr = 1'b1;
    @(negedge sys_clk);
    user_wr = 1'b0;
  endtask

  // Hold of n cycles, then settle
  task automatic hold(input int n);
    scc_btn_model_inst.press(n);
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic t_reset;
    chk_cfg(ch0_cfg, CFG_DEFAULT);
    chk_val(32'(ch0_stop_bits), 32'h1);
    chk_val(32'(default_comm_indicator), 32'h1);
  endtask

  // Write while defaults run, then a zero timeout that must be ignored
  task automatic t_short;
    wr(UCFG);
    wr(BAD);
    chk_cfg(ch0_cfg, CFG_DEFAULT);
    hold(15);
    chk_val(32'(n_tog), 32'h0);
  endtask

  task automatic t_swap;
    hold(80);
    chk_val(32'(n_tog), 32'h1);
    chk_val(32'(default_comm_indicator), 32'h0);
    chk_cfg(ch0_cfg, UCFG);
    chk_val(32'(ch0_stop_bits), 32'h1);
    hold(30);
    chk_cfg(ch0_cfg, CFG_DEFAULT);
    chk_val(32'(default_comm_indicator), 32'h1);
  endtask

  task automatic t_upgrade;
    hold(30);
    chk_cfg(ch0_cfg, UCFG);
    @(negedge sys_clk);
    fw_upgrade_done = 1'b1;
    @(negedge sys_clk);
    fw_upgrade_done = 1'b0;
    chk_cfg(ch0_cfg, CFG_DEFAULT);
    chk_val(32'(default_comm_indicator), 32'h1);
  endtask

  // One-cycle pulse on the power-up input
  task automatic pulse_pu;
    @(negedge sys_clk);
    first_powerup = 1'b1;
    @(negedge sys_clk);
    first_powerup = 1'b0;
  endtask

  // Power-up load is one-shot per reset; reset loads CFG_DEFAULT into the user set
  task automatic t_powerup;
    hold(30);
    pulse_pu();
    chk_val(32'(default_comm_indicator), 32'h1);
    chk_cfg(ch0_cfg, CFG_DEFAULT);
    hold(30);
    pulse_pu();
    chk_cfg(ch0_cfg, UCFG);
    chk_val(32'(default_comm_indicator), 32'h0);
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    chk_cfg(ch0_cfg, CFG_DEFAULT);
    chk_val(32'(default_comm_indicator), 32'h1);
    hold(30);
    chk_cfg(ch0_cfg, CFG_DEFAULT);
    chk_val(32'(default_comm_indicator), 32'h0);
    pulse_pu();
    chk_val(32'(default_comm_indicator), 32'h1);
    chk_val(32'(n_tog), 32'h6);
  endtask

  initial begin
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_short();
    t_swap();
    t_upgrade();
    t_powerup();
    give_verdict();
  end
endmodule
